// [common/sysctl_pkg.sv]
package sysctl_pkg;

  // Register port geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int HIGH_PAGE_BIT = 4;
  localparam int HIGH_PAGE_SLOTS = 8;

  // Register offsets: one direct-page slot, four of the eight high-page slots
  localparam logic [ADDR_W-1:0] ADDR_PIN_STATUS = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_CAUSE = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_PWR1 = 5'h11;
  localparam logic [ADDR_W-1:0] ADDR_PWR2 = 5'h12;
  localparam logic [ADDR_W-1:0] ADDR_RTI = 5'h13;

  // power_ctrl_reg1 fields
  localparam int PWR1_FLAG = 7;
  localparam int PWR1_ACK = 6;
  localparam int PWR1_IE = 5;
  localparam int PWR1_RE = 4;
  localparam int PWR1_SE = 3;
  localparam int PWR1_EN = 2;
  // power_ctrl_reg2 fields
  localparam int PWR2_WARN = 7;
  localparam int PWR2_WACK = 6;
  localparam int PWR2_TRIP = 5;
  localparam int PWR2_WTRIP = 4;
  // periodic_int_ctrl_reg fields
  localparam int RTI_FLAG = 7;
  localparam int RTI_ACK = 6;
  localparam int RTI_SRC = 5;
  localparam int RTI_IE = 4;
  localparam int RTI_SEL_LSB = 0;
  localparam int RTI_SEL_W = 3;
  // reset_cause_reg fields
  localparam int CAUSE_POR = 7;
  localparam int CAUSE_PIN = 6;
  localparam int CAUSE_WDOG = 5;
  localparam int CAUSE_ILOP = 4;
  localparam int CAUSE_LVD = 1;
  // pin status slot fields
  localparam int PIN_FLAG = 3;
  localparam int PIN_IE = 1;

  // Reset values
  localparam logic [DATA_W-1:0] PWR1_RST = 8'h14;
  localparam logic [DATA_W-1:0] PWR2_RST = 8'h00;
  localparam logic [DATA_W-1:0] RTI_RST = 8'h00;
  localparam logic [DATA_W-1:0] CAUSE_RST = 8'h82;

  // Vector map
  localparam int NUM_VEC = 26;
  localparam logic [15:0] VEC_TOP = 16'hFFFE;
  localparam int VEC_SWI = 1;
  localparam int VEC_PIN = 2;
  localparam int VEC_LOWV = 3;
  localparam int VEC_CLKGEN = 4;
  localparam int VEC_T1 = 5;
  localparam int VEC_T2 = 9;
  localparam int VEC_PERIODIC = 25;

  // Periodic unit timing
  localparam int PERIOD_SHIFT = 3;
  localparam int RTI_CNT_W = PERIOD_SHIFT + 8;
  localparam int INT_CLK_DIV = 200;

  typedef enum logic [2:0] {
    MODE_RUN, MODE_WAIT, MODE_STOP3, MODE_STOP2, MODE_STOP1
  } power_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic por;
    logic below_hi;
    logic below_lo;
    logic warn_hi;
    logic warn_lo;
  } volt_cmp_t;

  typedef struct packed {
    logic swi;
    logic pin_flag;
    logic pin_ie;
    logic clkgen_flag;
    logic clkgen_ie;
    logic [3:0] t1_flag;
    logic [3:0] t1_ie;
    logic [1:0] t2_flag;
    logic [1:0] t2_ie;
  } periph_req_t;

endpackage

// [rtl/sys_ctrl.sv]
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module sys_ctrl #(
  parameter int INT_CLK_DIV = sysctl_pkg::INT_CLK_DIV
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire sysctl_pkg::reg_req_t reg_req_in,
  output logic [sysctl_pkg::DATA_W-1:0] reg_rdata_out,
  input wire sysctl_pkg::volt_cmp_t volt_cmp_in,
  input wire logic reset_pin_in,
  input wire logic ext_ref_clock_in,
  input wire logic watchdog_timeout_in,
  input wire logic watchdog_enable_in,
  input wire logic illegal_opcode_in,
  input wire sysctl_pkg::periph_req_t periph_req_in,
  input wire sysctl_pkg::power_mode_t power_mode_in,
  input wire logic stop_req_in,
  input wire sysctl_pkg::power_mode_t stop_target_in,
  output logic stop_grant_out,
  output logic stop_refuse_out,
  output logic reset_req_out,
  output logic int_req_out,
  output logic [15:0] vector_addr_out,
  output logic lowv_detector_on_out,
  output logic watchdog_clear_out
);

  if (INT_CLK_DIV < 2) begin : g_div_check
    $error("INT_CLK_DIV must be at least 2");
  end

  localparam int DIV_W = $clog2(INT_CLK_DIV);
  localparam int SYNC_W = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic ext_prev_r;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
      ext_prev_r <= 1'b0;
    end else begin
      sync1_r <= {volt_cmp_in, reset_pin_in, ext_ref_clock_in};
      sync2_r <= sync1_r;
      ext_prev_r <= sync2_r[0];
    end
  end

  sysctl_pkg::volt_cmp_t volt;
  logic pin_rst;
  logic ext_tick;
  assign volt = sysctl_pkg::volt_cmp_t'(sync2_r[SYNC_W-1:2]);
  assign pin_rst = sync2_r[1];
  assign ext_tick = sync2_r[0] & ~ext_prev_r; // Rising edge of reference

  ////////////////////////////////////////////////////////////////////////////
  // Register file and low-voltage state
  logic [7:0] pwr1_r, pwr1_nxt;
  logic [7:0] pwr2_r, pwr2_nxt;
  logic [7:0] rti_r, rti_nxt;
  logic [7:0] cause_r, cause_nxt;
  logic por_hold_r, por_hold_nxt;
  logic lvr_hold_r, lvr_hold_nxt;
  logic rst_prev_r, rst_prev_nxt;
  logic rti_fire;

  logic in_stop;
  logic det_on;
  logic below_sel;
  logic warn_sel;
  logic other_rst;
  logic wr_pwr1, wr_pwr2, wr_rti, wr_cause;

  // Decode of bus writes, one slot each
  assign wr_pwr1 = reg_req_in.wr && reg_req_in.addr == sysctl_pkg::ADDR_PWR1;
  assign wr_pwr2 = reg_req_in.wr && reg_req_in.addr == sysctl_pkg::ADDR_PWR2;
  assign wr_rti = reg_req_in.wr && reg_req_in.addr == sysctl_pkg::ADDR_RTI;
  assign wr_cause = reg_req_in.wr && reg_req_in.addr == sysctl_pkg::ADDR_CAUSE;

  assign in_stop = power_mode_in inside {sysctl_pkg::MODE_STOP1, sysctl_pkg::MODE_STOP2,
                                         sysctl_pkg::MODE_STOP3};
  // Detector is dropped in stop to save current unless kept alive
  assign det_on = pwr1_r[sysctl_pkg::PWR1_EN] &&
                  (!in_stop || pwr1_r[sysctl_pkg::PWR1_SE]);
  assign below_sel = pwr2_r[sysctl_pkg::PWR2_TRIP] ? volt.below_hi : volt.below_lo;
  assign warn_sel = pwr2_r[sysctl_pkg::PWR2_WTRIP] ? volt.warn_hi : volt.warn_lo;
  // Watchdog timeout only gives a reset when its enable is set
  assign other_rst = (watchdog_enable_in && watchdog_timeout_in) || pin_rst || illegal_opcode_in;

  // Next state for control registers and reset holds
  always_comb begin
    pwr1_nxt = pwr1_r;
    pwr2_nxt = pwr2_r;
    rti_nxt = rti_r;
    cause_nxt = cause_r;
    por_hold_nxt = por_hold_r;
    lvr_hold_nxt = lvr_hold_r;
    rst_prev_nxt = por_hold_r || lvr_hold_r || other_rst;
    if (wr_pwr1) begin
      pwr1_nxt[5:2] = reg_req_in.wdata[5:2];
      if (reg_req_in.wdata[sysctl_pkg::PWR1_ACK]) begin
        pwr1_nxt[sysctl_pkg::PWR1_FLAG] = 1'b0;
      end
    end
    if (wr_pwr2) begin
      pwr2_nxt[5:4] = reg_req_in.wdata[5:4];
      if (reg_req_in.wdata[sysctl_pkg::PWR2_WACK]) begin
        pwr2_nxt[sysctl_pkg::PWR2_WARN] = 1'b0;
      end
    end
    if (wr_rti) begin
      rti_nxt[5:0] = reg_req_in.wdata[5:0];
      if (reg_req_in.wdata[sysctl_pkg::RTI_ACK]) begin
        rti_nxt[sysctl_pkg::RTI_FLAG] = 1'b0;
      end
    end
    // Flag sets come after clears so an event on the clear cycle survives
    if (det_on && below_sel && pwr1_r[sysctl_pkg::PWR1_IE] && !pwr1_r[sysctl_pkg::PWR1_RE]) begin
      pwr1_nxt[sysctl_pkg::PWR1_FLAG] = 1'b1;
    end
    if (det_on && warn_sel && !below_sel) begin
      pwr2_nxt[sysctl_pkg::PWR2_WARN] = 1'b1;
    end
    if (rti_fire) begin
      rti_nxt[sysctl_pkg::RTI_FLAG] = 1'b1;
    end
    // Power-on hold releases only above the low trip
    if (volt.por) begin
      por_hold_nxt = 1'b1;
    end else if (!volt.below_lo) begin
      por_hold_nxt = 1'b0;
    end
    // Low-voltage reset releases above whichever trip is selected
    if (det_on && pwr1_r[sysctl_pkg::PWR1_RE] && below_sel) begin
      lvr_hold_nxt = 1'b1;
    end else if (!below_sel) begin
      lvr_hold_nxt = 1'b0;
    end
    // Cause captured at the start of each reset
    if (volt.por) begin
      cause_nxt = sysctl_pkg::CAUSE_RST;
    end else if (rst_prev_nxt && !rst_prev_r) begin
      cause_nxt = '0;
      cause_nxt[sysctl_pkg::CAUSE_POR] = cause_r[sysctl_pkg::CAUSE_POR] && lvr_hold_nxt;
      cause_nxt[sysctl_pkg::CAUSE_LVD] = lvr_hold_nxt;
      cause_nxt[sysctl_pkg::CAUSE_PIN] = pin_rst;
      cause_nxt[sysctl_pkg::CAUSE_WDOG] = watchdog_enable_in && watchdog_timeout_in;
      cause_nxt[sysctl_pkg::CAUSE_ILOP] = illegal_opcode_in;
    end
    // Control bits return to defaults while a power-on or low-voltage hold lasts, except PWR2_TRIP under the low-voltage hold
    if (por_hold_r || lvr_hold_r) begin
      pwr1_nxt = sysctl_pkg::PWR1_RST;
      pwr2_nxt = sysctl_pkg::PWR2_RST;
      pwr2_nxt[sysctl_pkg::PWR2_TRIP] = !por_hold_r && pwr2_r[sysctl_pkg::PWR2_TRIP];
      rti_nxt = sysctl_pkg::RTI_RST;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pwr1_r <= sysctl_pkg::PWR1_RST;
      pwr2_r <= sysctl_pkg::PWR2_RST;
      rti_r <= sysctl_pkg::RTI_RST;
      cause_r <= sysctl_pkg::CAUSE_RST;
      por_hold_r <= 1'b0;
      lvr_hold_r <= 1'b0;
      rst_prev_r <= 1'b0;
    end else begin
      pwr1_r <= pwr1_nxt;
      pwr2_r <= pwr2_nxt;
      rti_r <= rti_nxt;
      cause_r <= cause_nxt;
      por_hold_r <= por_hold_nxt;
      lvr_hold_r <= lvr_hold_nxt;
      rst_prev_r <= rst_prev_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Periodic interrupt unit
  logic [DIV_W-1:0] div_r, div_nxt;
  logic [sysctl_pkg::RTI_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [sysctl_pkg::RTI_SEL_W-1:0] sel;
  logic [sysctl_pkg::RTI_CNT_W-1:0] limit;
  logic int_tick;
  logic src_tick;

  assign sel = rti_r[sysctl_pkg::RTI_SEL_LSB +: sysctl_pkg::RTI_SEL_W];
  // Power-of-two multiples keep the compare a single shift
  assign limit = (sysctl_pkg::RTI_CNT_W'(1) << ({1'b0, sel} + 4'(sysctl_pkg::PERIOD_SHIFT)))
                 - sysctl_pkg::RTI_CNT_W'(1);
  assign int_tick = div_r == DIV_W'(INT_CLK_DIV - 1);

  // Source choice by mode; deepest stop gets nothing
  always_comb begin
    unique case (power_mode_in)
      sysctl_pkg::MODE_RUN, sysctl_pkg::MODE_WAIT: src_tick = ext_tick;
      sysctl_pkg::MODE_STOP2: src_tick = int_tick;
      sysctl_pkg::MODE_STOP3: src_tick = rti_r[sysctl_pkg::RTI_SRC] ? int_tick : ext_tick;
      sysctl_pkg::MODE_STOP1: src_tick = 1'b0;
      default: src_tick = 1'b0;
    endcase
  end

  // Internal clock divider and period counter
  always_comb begin
    div_nxt = int_tick ? '0 : div_r + DIV_W'(1);
    cnt_nxt = cnt_r;
    rti_fire = 1'b0;
    if (sel == '0) begin
      div_nxt = '0;
      cnt_nxt = '0;
    end else if (src_tick) begin
      if (cnt_r >= limit) begin
        cnt_nxt = '0;
        rti_fire = 1'b1;
      end else begin
        cnt_nxt = cnt_r + sysctl_pkg::RTI_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      div_r <= '0;
      cnt_r <= '0;
    end else begin
      div_r <= div_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request vector and priority pick
  logic [sysctl_pkg::NUM_VEC-1:0] flag_v;
  logic [sysctl_pkg::NUM_VEC-1:0] en_v;
  logic [sysctl_pkg::NUM_VEC-1:0] req_v;

  always_comb begin
    flag_v = '0;
    en_v = '0;
    flag_v[sysctl_pkg::VEC_SWI] = periph_req_in.swi;
    en_v[sysctl_pkg::VEC_SWI] = 1'b1; // Software interrupt has no mask
    flag_v[sysctl_pkg::VEC_PIN] = periph_req_in.pin_flag;
    en_v[sysctl_pkg::VEC_PIN] = periph_req_in.pin_ie;
    flag_v[sysctl_pkg::VEC_LOWV] = pwr1_r[sysctl_pkg::PWR1_FLAG];
    en_v[sysctl_pkg::VEC_LOWV] = pwr1_r[sysctl_pkg::PWR1_IE];
    flag_v[sysctl_pkg::VEC_CLKGEN] = periph_req_in.clkgen_flag;
    en_v[sysctl_pkg::VEC_CLKGEN] = periph_req_in.clkgen_ie;
    flag_v[sysctl_pkg::VEC_T1 +: 4] = periph_req_in.t1_flag;
    en_v[sysctl_pkg::VEC_T1 +: 4] = periph_req_in.t1_ie;
    flag_v[sysctl_pkg::VEC_T2 +: 2] = periph_req_in.t2_flag;
    en_v[sysctl_pkg::VEC_T2 +: 2] = periph_req_in.t2_ie;
    flag_v[sysctl_pkg::VEC_PERIODIC] = rti_r[sysctl_pkg::RTI_FLAG];
    en_v[sysctl_pkg::VEC_PERIODIC] = rti_r[sysctl_pkg::RTI_IE];
  end

  // Every source except the software interrupt masked by its own enable
  for (genvar i = 0; i < sysctl_pkg::NUM_VEC; i++) begin : g_mask
    assign req_v[i] = flag_v[i] & en_v[i];
  end

  logic any_req;
  logic [4:0] win;

  // Scan downward from highest number so the lowest number ends up winning
  always_comb begin
    any_req = 1'b0;
    win = '0;
    for (int i = sysctl_pkg::NUM_VEC - 1; i > 0; i--) begin
      if (req_v[i]) begin
        any_req = 1'b1;
        win = 5'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  logic [7:0] rdata_r, rdata_nxt;
  logic rst_r, rst_nxt;
  logic irq_r, irq_nxt;
  logic [15:0] vec_r, vec_nxt;
  logic det_r, det_nxt;
  logic grant_r, grant_nxt;
  logic refuse_r, refuse_nxt;
  logic wdclr_r, wdclr_nxt;
  logic deep_block;

  assign deep_block = pwr1_r[sysctl_pkg::PWR1_SE] && pwr1_r[sysctl_pkg::PWR1_EN];

  // Read mux; write-only ack bits read back as zero
  always_comb begin
    rdata_nxt = '0;
    if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        sysctl_pkg::ADDR_PIN_STATUS: begin
          rdata_nxt[sysctl_pkg::PIN_FLAG] = periph_req_in.pin_flag;
          rdata_nxt[sysctl_pkg::PIN_IE] = periph_req_in.pin_ie;
        end
        sysctl_pkg::ADDR_CAUSE: rdata_nxt = cause_r;
        sysctl_pkg::ADDR_PWR1: rdata_nxt = pwr1_r & 8'hBF;
        sysctl_pkg::ADDR_PWR2: rdata_nxt = pwr2_r & 8'hB0;
        sysctl_pkg::ADDR_RTI: rdata_nxt = rti_r & 8'hBF;
        default: rdata_nxt = '0; // Rest of high page and unmapped read zero
      endcase
    end
  end

  always_comb begin
    rst_nxt = por_hold_nxt || lvr_hold_nxt || other_rst;
    irq_nxt = any_req && !rst_nxt;
    // High-byte address; low byte is at the next address up
    vec_nxt = rst_nxt ? sysctl_pkg::VEC_TOP
                      : sysctl_pkg::VEC_TOP - {10'h000, win, 1'b0};
    det_nxt = det_on;
    grant_nxt = 1'b0;
    refuse_nxt = 1'b0;
    if (stop_req_in) begin
      if (deep_block && stop_target_in inside {sysctl_pkg::MODE_STOP1, sysctl_pkg::MODE_STOP2}) begin
        refuse_nxt = 1'b1;
      end else begin
        grant_nxt = 1'b1;
      end
    end
    wdclr_nxt = wr_cause; // Any write to the cause slot kicks the watchdog
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rdata_r <= '0;
      rst_r <= 1'b0;
      irq_r <= 1'b0;
      vec_r <= sysctl_pkg::VEC_TOP;
      det_r <= 1'b0;
      grant_r <= 1'b0;
      refuse_r <= 1'b0;
      wdclr_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rst_r <= rst_nxt;
      irq_r <= irq_nxt;
      vec_r <= vec_nxt;
      det_r <= det_nxt;
      grant_r <= grant_nxt;
      refuse_r <= refuse_nxt;
      wdclr_r <= wdclr_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign reset_req_out = rst_r;
  assign int_req_out = irq_r;
  assign vector_addr_out = vec_r;
  assign lowv_detector_on_out = det_r;
  assign stop_grant_out = grant_r;
  assign stop_refuse_out = refuse_r;
  assign watchdog_clear_out = wdclr_r;

endmodule

`default_nettype wire

// [dv/sys_ctrl_chk.sv]
`timescale 1ns/1ps
`default_nettype none

module sys_ctrl_chk (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire sysctl_pkg::reg_req_t reg_req_in,
  input wire logic [sysctl_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic reset_pin_in,
  input wire logic watchdog_timeout_in,
  input wire logic watchdog_enable_in,
  input wire logic illegal_opcode_in,
  input wire sysctl_pkg::periph_req_t periph_req_in,
  input wire logic stop_req_in,
  input wire sysctl_pkg::power_mode_t stop_target_in,
  input wire logic stop_grant_out,
  input wire logic stop_refuse_out,
  input wire logic reset_req_out,
  input wire logic int_req_out,
  input wire logic [15:0] vector_addr_out,
  input wire logic watchdog_clear_out
);
  // One clock domain, so one default clock and disable
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  ////////////////////////////////////////////////////////////////////////////
  // Reset sources and their gating
  property p_wdog_reset;
    watchdog_timeout_in && watchdog_enable_in |=> reset_req_out;
  endproperty
  a_wdog_reset: assert property (p_wdog_reset)
    else $error("enabled watchdog timeout gave no reset");
  property p_ilop_reset;
    illegal_opcode_in |=> reset_req_out;
  endproperty
  a_ilop_reset: assert property (p_ilop_reset)
    else $error("illegal opcode gave no reset");
  // Pin passes a two-stage synchroniser first
  property p_pin_reset;
    $rose(reset_pin_in) |-> ##[1:4] reset_req_out;
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("reset pin gave no reset");
  property p_reset_masks_int;
    reset_req_out |-> !int_req_out;
  endproperty
  a_reset_masks_int: assert property (p_reset_masks_int)
    else $error("interrupt raised during reset");
  property p_wdog_clear;
    watchdog_clear_out == $past(reg_req_in.wr && reg_req_in.addr == sysctl_pkg::ADDR_CAUSE);
  endproperty
  a_wdog_clear: assert property (p_wdog_clear)
    else $error("watchdog clear pulse wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Vectors and priority
  property p_swi_top;
    periph_req_in.swi && !reset_req_out ##1 !reset_req_out |-> int_req_out && vector_addr_out == 16'hFFFC;
  endproperty
  a_swi_top: assert property (p_swi_top)
    else $error("software interrupt did not win");
  property p_vec_even;
    int_req_out |-> vector_addr_out[0] == 1'b0 && vector_addr_out >= 16'hFFCC;
  endproperty
  a_vec_even: assert property (p_vec_even)
    else $error("vector address not a high-byte slot");

  ////////////////////////////////////////////////////////////////////////////
  // Stop entry answers
  property p_stop_answer;
    stop_req_in |=> stop_grant_out != stop_refuse_out;
  endproperty
  a_stop_answer: assert property (p_stop_answer)
    else $error("stop request not answered once");
  property p_stop3_grant;
    stop_req_in && stop_target_in == sysctl_pkg::MODE_STOP3 |=> stop_grant_out;
  endproperty
  a_stop3_grant: assert property (p_stop3_grant)
    else $error("lightest stop refused");

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  property p_unmapped;
    reg_req_in.rd && reg_req_in.addr inside {[5'h14:5'h17]} |=> reg_rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unused slot read nonzero");
endmodule

// Attach to every instance of the block
bind sys_ctrl sys_ctrl_chk u_chk (
  .clk_in(clk_in),
  .resetn_in(resetn_in),
  .reg_req_in(reg_req_in),
  .reg_rdata_out(reg_rdata_out),
  .reset_pin_in(reset_pin_in),
  .watchdog_timeout_in(watchdog_timeout_in),
  .watchdog_enable_in(watchdog_enable_in),
  .illegal_opcode_in(illegal_opcode_in),
  .periph_req_in(periph_req_in),
  .stop_req_in(stop_req_in),
  .stop_target_in(stop_target_in),
  .stop_grant_out(stop_grant_out),
  .stop_refuse_out(stop_refuse_out),
  .reset_req_out(reset_req_out),
  .int_req_out(int_req_out),
  .vector_addr_out(vector_addr_out),
  .watchdog_clear_out(watchdog_clear_out)
);

`default_nettype wire

// [dv/cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none

module cpu_model (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic int_req_in,
  input wire logic [15:0] vector_in,
  output logic [15:0] fetched_out
);
  // Vector address taken on every cycle with a request; the last one is kept
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      fetched_out <= 16'hFFFE;
    end else if (int_req_in) begin
      fetched_out <= vector_in;
    end
  end
endmodule

`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk_in, resetn_in, ext_ref_clock_in, ext_run, reset_pin_in, wd_to, wd_en, ilop, stop_req;
  logic grant, refuse, rst_req, int_req, det_on;
  logic [1:0] ediv;
  logic [7:0] rdata;
  logic [15:0] vec, fetched;
  sysctl_pkg::reg_req_t req;
  sysctl_pkg::volt_cmp_t volt;
  sysctl_pkg::periph_req_t per;
  sysctl_pkg::power_mode_t mode, tgt;
  int n_fail, checked;
  logic [4:0] ra [5] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h14};
  logic [7:0] rv [5] = '{8'h82, 8'h14, 8'h00, 8'h00, 8'h00};
  // Periodic cases: mode, source bit, external clock running, flag expected
  logic [5:0] tbl [8] = '{6'h03, 6'h0B, 6'h00, 6'h19, 6'h15, 6'h13, 6'h10, 6'h22};

  // Small internal divider keeps the periodic runs short
  sys_ctrl #(.INT_CLK_DIV(4)) DUT (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .reg_req_in(req),
    .reg_rdata_out(rdata),
    .volt_cmp_in(volt),
    .reset_pin_in(reset_pin_in),
    .ext_ref_clock_in(ext_ref_clock_in),
    .watchdog_timeout_in(wd_to),
    .watchdog_enable_in(wd_en),
    .illegal_opcode_in(ilop),
    .periph_req_in(per),
    .power_mode_in(mode),
    .stop_req_in(stop_req),
    .stop_target_in(tgt),
    .stop_grant_out(grant),
    .stop_refuse_out(refuse),
    .reset_req_out(rst_req),
    .int_req_out(int_req),
    .vector_addr_out(vec),
    .lowv_detector_on_out(det_on),
    .watchdog_clear_out()
  );
  cpu_model u_cpu (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .int_req_in(int_req),
    .vector_in(vec),
    .fetched_out(fetched)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Reference clock of four cycles, frozen when not wanted
  always @(posedge clk_in) begin
    if (ext_run) begin
      ediv <= ediv + 2'h1;
      ext_ref_clock_in <= ediv[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  // Samples 1 ns past the edge so the design's updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk_in);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clk_in);
    req.wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk_in);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_in);
    req.rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rdata});
  endtask
  // Bounded wait; running out ends the run
  task automatic waitr(input logic v);
    for (int i = 0; i < 64 && rst_req !== v; i++) tick(1);
    chkb("reset_req", v, rst_req);
    if (rst_req !== v) give_verdict();
  endtask
  task automatic stop(input logic [2:0] t, input logic r);
    @(posedge clk_in);
    stop_req <= 1'b1;
    tgt <= sysctl_pkg::power_mode_t'(t);
    @(posedge clk_in);
    stop_req <= 1'b0;
    #1;
    chkb("stop_refuse", r, refuse);
    chkb("stop_grant", !r, grant);
  endtask
  task automatic src(input int n, input logic ie);
    sysctl_pkg::periph_req_t p;
    p = '0;
    case (n)
      1: p.swi = 1'b1;
      2: begin
        p.pin_flag = 1'b1;
        p.pin_ie = ie;
      end
      4: begin
        p.clkgen_flag = 1'b1;
        p.clkgen_ie = ie;
      end
      9, 10: begin
        p.t2_flag[n-9] = 1'b1;
        p.t2_ie[n-9] = ie;
      end
      default: begin
        p.t1_flag[n-5] = 1'b1;
        p.t1_ie[n-5] = ie;
      end
    endcase
    @(posedge clk_in);
    per <= p;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn_in, ext_run, ediv, ext_ref_clock_in, reset_pin_in, wd_to, wd_en, ilop, stop_req} = '0;
    req = '0;
    volt = '0;
    per = '0;
    mode = sysctl_pkg::MODE_RUN;
    tgt = sysctl_pkg::MODE_RUN;
    n_fail = 0;
    checked = 0;
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    // Reset values, read-only places and an unused slot
    for (int i = 0; i < 5; i++) rdc(ra[i], rv[i]);
    wr(sysctl_pkg::ADDR_CAUSE, 8'hFF);
    rdc(sysctl_pkg::ADDR_CAUSE, 8'h82);
    wr(sysctl_pkg::ADDR_PWR1, 8'hFF);
    rdc(sysctl_pkg::ADDR_PWR1, 8'h3C);
    // Each source alone, masked then enabled; software has no mask
    for (int n = 1; n <= 10; n++) begin
      for (int e = 0; e < 2; e++) begin
        if (n == 3) continue;
        src(n, e[0]);
        tick(3);
        chkb("int_req", n == 1 || e == 1, int_req);
        if (n == 1 || e == 1) chk("vector", 16'hFFFE - 16'(2 * n), fetched);
      end
    end
    src(10, 1'b1);
    @(posedge clk_in);
    per.pin_flag <= 1'b1;
    per.pin_ie <= 1'b1;
    tick(3);
    chk("vector", 16'hFFFA, fetched);
    rdc(sysctl_pkg::ADDR_PIN_STATUS, 8'h0A);
    per <= '0;
    // Stop entry with detector kept alive in stop
    wr(sysctl_pkg::ADDR_PWR1, 8'h0C);
    stop(3'h4, 1'b1);
    stop(3'h3, 1'b1);
    stop(3'h2, 1'b0);
    mode <= sysctl_pkg::MODE_STOP3;
    tick(4);
    chkb("det_on", 1'b1, det_on);
    wr(sysctl_pkg::ADDR_PWR1, 8'h04);
    stop(3'h4, 1'b0);
    tick(4);
    chkb("det_on", 1'b0, det_on);
    mode <= sysctl_pkg::MODE_RUN;
    // Detector interrupt on the low trip; high trip ignored
    wr(sysctl_pkg::ADDR_PWR1, 8'h24);
    volt.below_hi <= 1'b1;
    tick(6);
    rdc(sysctl_pkg::ADDR_PWR1, 8'h24);
    volt.below_lo <= 1'b1;
    tick(6);
    rdc(sysctl_pkg::ADDR_PWR1, 8'hA4);
    chk("vector", 16'hFFF8, fetched);
    wr(sysctl_pkg::ADDR_PWR1, 8'h64);
    rdc(sysctl_pkg::ADDR_PWR1, 8'hA4);
    volt <= '0;
    tick(6);
    wr(sysctl_pkg::ADDR_PWR1, 8'h64);
    rdc(sysctl_pkg::ADDR_PWR1, 8'h24);
    wr(sysctl_pkg::ADDR_PWR1, 8'h20);
    volt.below_lo <= 1'b1;
    tick(6);
    rdc(sysctl_pkg::ADDR_PWR1, 8'h20);
    // Warning flag on its own trip, never an interrupt
    volt <= 5'b00010;
    wr(sysctl_pkg::ADDR_PWR1, 8'h24);
    tick(6);
    rdc(sysctl_pkg::ADDR_PWR2, 8'h00);
    volt <= 5'b00011;
    tick(6);
    rdc(sysctl_pkg::ADDR_PWR2, 8'h80);
    chkb("int_req", 1'b0, int_req);
    volt <= '0;
    tick(6);
    wr(sysctl_pkg::ADDR_PWR2, 8'h40);
    rdc(sysctl_pkg::ADDR_PWR2, 8'h00);
    // Low-voltage reset on the high trip, held until supply recovers
    wr(sysctl_pkg::ADDR_PWR1, 8'h14);
    wr(sysctl_pkg::ADDR_PWR2, 8'h20);
    volt.below_hi <= 1'b1;
    waitr(1'b1);
    tick(20);
    chkb("reset_req", 1'b1, rst_req);
    volt <= '0;
    waitr(1'b0);
    rdc(sysctl_pkg::ADDR_CAUSE, 8'h82);
    // Power-on held until above the low trip
    volt <= 5'b11100;
    waitr(1'b1);
    volt <= 5'b00100;
    tick(20);
    chkb("reset_req", 1'b1, rst_req);
    volt <= '0;
    waitr(1'b0);
    rdc(sysctl_pkg::ADDR_CAUSE, 8'h82);
    // Top vector sources; watchdog gated by its enable
    wd_to <= 1'b1;
    tick(6);
    chkb("reset_req", 1'b0, rst_req);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_in);
      reset_pin_in <= (k == 0);
      wd_en <= (k == 1);
      ilop <= (k == 2);
      waitr(1'b1);
      @(posedge clk_in);
      reset_pin_in <= 1'b0;
      wd_en <= 1'b0;
      ilop <= 1'b0;
      waitr(1'b0);
      rdc(sysctl_pkg::ADDR_CAUSE, 8'h40 >> k);
    end
    wd_to <= 1'b0;
    // Period of 16 ticks from a cleared counter, then masking and disable
    ext_run <= 1'b1;
    wr(sysctl_pkg::ADDR_RTI, 8'h00);
    wr(sysctl_pkg::ADDR_RTI, 8'h11);
    tick(46);
    rdc(sysctl_pkg::ADDR_RTI, 8'h11);
    tick(40);
    rdc(sysctl_pkg::ADDR_RTI, 8'h91);
    chk("vector", 16'hFFCC, fetched);
    wr(sysctl_pkg::ADDR_RTI, 8'h41);
    tick(80);
    rdc(sysctl_pkg::ADDR_RTI, 8'h81);
    chkb("int_req", 1'b0, int_req);
    wr(sysctl_pkg::ADDR_RTI, 8'h40);
    tick(160);
    rdc(sysctl_pkg::ADDR_RTI, 8'h00);
    // Clock source per mode; oscillator kept running in stop by software
    for (int c = 0; c < 8; c++) begin
      @(posedge clk_in);
      mode <= sysctl_pkg::power_mode_t'(tbl[c][5:3]);
      ext_run <= tbl[c][1];
      wr(sysctl_pkg::ADDR_RTI, 8'h00);
      wr(sysctl_pkg::ADDR_RTI, {2'b01, tbl[c][2], 5'h01});
      tick(160);
      rdc(sysctl_pkg::ADDR_RTI, {tbl[c][0], 1'b0, tbl[c][2], 5'h01});
    end
    give_verdict();
  end
endmodule

`default_nettype wire
